/* fce_pkg.sv */
// constants, types and command steps for the dual-die flash host controller
package fce_pkg;
  localparam int ADDR_W = 23;                 // 8,388,608 bytes per die
  localparam int SECTORS = 256;               // uniform 64 Kbyte sectors
  localparam int CLK_NS = 4;                  // ref_clk period
  // bus timing in ns, converted to whole cycles rounded up
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_BUSY_NS = 90;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;                // pin synchroniser latency
  // typical algorithm times; only the erase time is used to size the busy timeout
  localparam longint PROG_TYP_US = 5;
  localparam longint ERASE_TYP_MS = 1600;
  localparam longint CYC_PER_MS = 1000000 / CLK_NS;
  localparam longint BUSY_LIMIT_DEF = ERASE_TYP_MS * CYC_PER_MS * SECTORS * 2;
  // command bus values
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002aa;
  localparam logic [7:0] UNLOCK_D1 = 8'haa;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hf0;

  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_CHIP_ERASE, OP_SUSPEND,
    OP_RESUME, OP_BYPASS_ENTER, OP_BYPASS_EXIT, OP_SOFT_RESET, OP_HW_RESET
  } fce_op_t;

  typedef struct packed {
    fce_op_t op;
    logic die;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic more;
  } fce_cmd_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } fce_rsp_t;

  typedef struct packed {
    logic die0SelectN;
    logic die1SelectN;
    logic writeEnN;
    logic outEnN;
    logic resetN;
    logic fastProgramEn;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dqOut;
    logic dqOe;
  } fce_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic last;
  } fce_step_t;

  localparam fce_pins_t PINS_RST = '{die0SelectN: 1'b1, die1SelectN: 1'b1, writeEnN: 1'b1,
    outEnN: 1'b1, resetN: 1'b1, fastProgramEn: 1'b0, addr: '0, dqOut: 8'h00, dqOe: 1'b0};
endpackage

/* fce_host.sv */
// host controller that drives a dual-die nor flash over its pins
`timescale 1ns/1ns
// What this block does
// [RULE1] only one die select is ever driven low, from the command's die bit.
// [RULE2] each die is addressed with 23 address bits and an 8-bit data bus.
// [RULE3] sector erase commands place the 64 Kbyte sector number in the upper address bits.
// [RULE4] every command byte goes out as a plain timed write cycle.
// [RULE5] after a program sequence the host waits for the device's own algorithm.
// [RULE6] in unlock-bypass mode a program is sent as just two write cycles.
// [RULE7] after an erase sequence the host waits for the embedded erase to end.
// [RULE8] whole-die erase or several sectors appended to one sector erase.
// [RULE9] only addressed sectors are erased; the host never touches others.
// [RULE10] completion is taken from the ready pin, synchronised and filtered.
// [RULE11] once ready the host may read or issue the next command.
// [RULE12] device drops writes during supply transitions; host cannot see it.
// [RULE13] protected sectors refuse program and erase; host reports completion only.
// [RULE14] erase may be suspended while busy and resumed later by command.
// [RULE15] a hardware reset pulse aborts any operation and clears host mode flags.
// [RULE16] holding the fast program pin counts as unlock-bypass mode.
// [RULE17] busy timeout is sized from the typical erase duration only, over all sectors, doubled.
// [RULE18] a fresh device is erased; the host assumes nothing else.
// [RULE19] erased bytes read as ff; programming only clears bits.
module fce_host #(
  parameter longint unsigned BUSY_LIMIT_CYC = fce_pkg::BUSY_LIMIT_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // user command port
  input wire logic cmdValid,
  output logic cmdReady,
  input fce_pkg::fce_cmd_t cmd,
  input wire logic fastMode,
  // user response port
  output fce_pkg::fce_rsp_t rsp,
  output logic bypassActive,
  output logic eraseSuspended,
  // flash pins
  output fce_pkg::fce_pins_t pins,
  input wire logic [7:0] dqIn,
  input wire logic opDonePin
);
  typedef enum {ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_SETTLE, ST_BUSY, ST_RD, ST_RST_LOW, ST_RST_REC} fce_state_t;
  fce_state_t state_q, state_d;
  fce_pkg::fce_cmd_t cmd_q, cmd_d;
  fce_pkg::fce_pins_t pins_q, pins_d;
  fce_pkg::fce_rsp_t rsp_q, rsp_d;
  logic [2:0] idx_q, idx_d;
  logic [8:0] cnt_q, cnt_d;
  logic [39:0] tmo_q, tmo_d;
  logic bypass_q, bypass_d;
  logic susp_q, susp_d;
  logic eraseRun_q, eraseRun_d;
  logic [2:0] doneSync_q;
  logic doneStable_q, doneStable_d;
  logic [7:0] dqS1_q, dqS2_q, dqS3_q;
  logic bypassEff;
  logic accept;
  fce_pkg::fce_step_t step;
  // bus value of write cycle idx for an operation
  function automatic fce_pkg::fce_step_t seqStep(fce_pkg::fce_op_t op, logic [2:0] idx, logic byp,
                                                 logic [fce_pkg::ADDR_W-1:0] a, logic [7:0] d);
    fce_pkg::fce_step_t s;
    logic [fce_pkg::ADDR_W-1:0] ua [6];
    logic [7:0] ud [6];
    s = '{addr: fce_pkg::UNLOCK_A1, data: fce_pkg::CMD_SOFT_RESET, last: 1'b1};
    ua = '{fce_pkg::UNLOCK_A1, fce_pkg::UNLOCK_A2, fce_pkg::UNLOCK_A1, fce_pkg::UNLOCK_A1,
           fce_pkg::UNLOCK_A2, fce_pkg::UNLOCK_A1};
    ud = '{fce_pkg::UNLOCK_D1, fce_pkg::UNLOCK_D2, fce_pkg::CMD_ERASE_SETUP, fce_pkg::UNLOCK_D1,
           fce_pkg::UNLOCK_D2, fce_pkg::CMD_CHIP_ERASE};
    case (op)
      fce_pkg::OP_PROGRAM: begin
        if (byp) begin
          s.addr = (idx == 3'd0) ? fce_pkg::UNLOCK_A1 : a; // [RULE6]
          s.data = (idx == 3'd0) ? fce_pkg::CMD_PROGRAM : d;
          s.last = (idx == 3'd1);
        end else begin
          s.addr = (idx == 3'd3) ? a : ua[idx];
          s.data = (idx == 3'd3) ? d : ((idx == 3'd2) ? fce_pkg::CMD_PROGRAM : ud[idx]);
          s.last = (idx == 3'd3);
        end
      end
      fce_pkg::OP_SECTOR_ERASE, fce_pkg::OP_CHIP_ERASE: begin
        s.addr = ua[idx];
        s.data = ud[idx];
        s.last = (idx == 3'd5);
        if (idx == 3'd5 && op == fce_pkg::OP_SECTOR_ERASE) begin
          s.addr = {a[fce_pkg::ADDR_W-1:16], 16'h0000}; // [RULE3] [RULE9]
          s.data = fce_pkg::CMD_SECTOR_ERASE;
        end
      end
      fce_pkg::OP_SECTOR_ADD: begin
        s.addr = {a[fce_pkg::ADDR_W-1:16], 16'h0000}; // [RULE8]
        s.data = fce_pkg::CMD_SECTOR_ERASE;
      end
      fce_pkg::OP_SUSPEND: s.data = fce_pkg::CMD_SUSPEND; // [RULE14]
      fce_pkg::OP_RESUME: s.data = fce_pkg::CMD_RESUME; // [RULE14]
      fce_pkg::OP_BYPASS_ENTER: begin
        s.addr = ua[idx];
        s.data = (idx == 3'd2) ? fce_pkg::CMD_BYPASS : ud[idx];
        s.last = (idx == 3'd2);
      end
      fce_pkg::OP_BYPASS_EXIT: begin
        s.data = (idx == 3'd0) ? fce_pkg::CMD_BYPASS_EXIT1 : fce_pkg::CMD_BYPASS_EXIT2;
        s.last = (idx == 3'd1);
      end
      default: s.data = fce_pkg::CMD_SOFT_RESET;
    endcase
    return s;
  endfunction
  // operations after which the host waits for the ready pin
  function automatic logic waitsBusy(fce_pkg::fce_cmd_t c);
    case (c.op)
      fce_pkg::OP_PROGRAM, fce_pkg::OP_RESUME, fce_pkg::OP_SUSPEND: return 1'b1;
      fce_pkg::OP_SECTOR_ERASE, fce_pkg::OP_SECTOR_ADD: return !c.more;
      fce_pkg::OP_CHIP_ERASE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // pin synchronisers: three stages, change taken when stages two and three agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      doneSync_q <= 3'b111; // idle level of the ready pin, no false busy after reset
      dqS1_q <= 8'h00;
      dqS2_q <= 8'h00;
      dqS3_q <= 8'h00;
    end else begin
      doneSync_q <= {doneSync_q[1:0], opDonePin};
      dqS1_q <= dqIn;
      dqS2_q <= dqS1_q;
      dqS3_q <= dqS2_q;
    end
  end
  assign doneStable_d = (doneSync_q[1] == doneSync_q[2]) ? doneSync_q[2] : doneStable_q; // [RULE10]
  assign bypassEff = bypass_q | pins_q.fastProgramEn; // [RULE16]
  assign step = seqStep(cmd_q.op, idx_q, bypassEff, cmd_q.addr, cmd_q.data);
  assign cmdReady = (state_q == ST_IDLE) ||
                    (state_q == ST_BUSY && eraseRun_q && cmd.op == fce_pkg::OP_SUSPEND); // [RULE14]
  assign accept = cmdValid && cmdReady;
  // next-state logic of the sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    pins_d = pins_q;
    rsp_d = '{valid: 1'b0, err: 1'b0, data: rsp_q.data};
    idx_d = idx_q;
    cnt_d = (cnt_q != 9'd0) ? cnt_q - 9'd1 : 9'd0;
    tmo_d = tmo_q;
    bypass_d = bypass_q;
    susp_d = susp_q;
    eraseRun_d = eraseRun_q;
    pins_d.fastProgramEn = fastMode;
    case (state_q)
      ST_IDLE: begin
        pins_d.die0SelectN = 1'b1;
        pins_d.die1SelectN = 1'b1;
        pins_d.outEnN = 1'b1;
        pins_d.dqOe = 1'b0;
        if (accept) begin
          cmd_d = cmd;
          idx_d = 3'd0;
          if (cmd.op == fce_pkg::OP_READ) begin
            state_d = ST_RD;
            cnt_d = 9'(fce_pkg::ACC_CYC + fce_pkg::SYNC_CYC - 1);
            pins_d.addr = cmd.addr; // [RULE2]
            pins_d.die0SelectN = cmd.die; // [RULE1]
            pins_d.die1SelectN = !cmd.die;
            pins_d.outEnN = 1'b0;
          end else if (cmd.op == fce_pkg::OP_HW_RESET) begin
            state_d = ST_RST_LOW;
            cnt_d = 9'(fce_pkg::RP_CYC - 1);
            pins_d.resetN = 1'b0; // [RULE15]
          end else begin
            state_d = ST_WR_LOW;
            cnt_d = 9'(fce_pkg::WP_CYC); // first write cycle only sets up the bus
            pins_d.die0SelectN = cmd.die; // [RULE1]
            pins_d.die1SelectN = !cmd.die;
          end
        end
      end
      ST_WR_LOW: begin
        pins_d.addr = step.addr; // [RULE4]
        pins_d.dqOut = step.data;
        pins_d.dqOe = 1'b1;
        pins_d.writeEnN = 1'b0;
        if (cnt_q == 9'd0 && !pins_q.writeEnN) begin
          state_d = ST_WR_HIGH;
          pins_d.writeEnN = 1'b1; // device latches on the rising edge
          cnt_d = 9'(fce_pkg::WPH_CYC - 1);
        end
      end
      ST_WR_HIGH: begin
        if (cnt_q == 9'd0) begin
          if (!step.last) begin
            idx_d = idx_q + 3'd1;
            state_d = ST_WR_LOW;
            cnt_d = 9'(fce_pkg::WP_CYC);
          end else begin
            pins_d.dqOe = 1'b0;
            case (cmd_q.op)
              fce_pkg::OP_BYPASS_ENTER: bypass_d = 1'b1;
              fce_pkg::OP_BYPASS_EXIT: bypass_d = 1'b0;
              fce_pkg::OP_SUSPEND: susp_d = 1'b1;
              fce_pkg::OP_RESUME: susp_d = 1'b0;
              default: ;
            endcase
            eraseRun_d = cmd_q.op inside {fce_pkg::OP_SECTOR_ERASE, fce_pkg::OP_SECTOR_ADD,
                                          fce_pkg::OP_CHIP_ERASE, fce_pkg::OP_RESUME};
            if (waitsBusy(cmd_q)) begin
              state_d = ST_SETTLE; // [RULE5] [RULE7]
              cnt_d = 9'(fce_pkg::BUSY_CYC + fce_pkg::SYNC_CYC);
              tmo_d = 40'd0;
            end else begin
              state_d = ST_IDLE;
              rsp_d.valid = 1'b1;
            end
          end
        end
      end
      ST_SETTLE: if (cnt_q == 9'd0) state_d = ST_BUSY;
      ST_BUSY: begin
        tmo_d = tmo_q + 40'd1;
        if (accept) begin
          cmd_d = cmd; // suspend the running erase
          idx_d = 3'd0;
          state_d = ST_WR_LOW;
          cnt_d = 9'(fce_pkg::WP_CYC);
          cmd_d.die = cmd_q.die; // selects stay low on the erasing die
        end else if (doneStable_q) begin
          state_d = ST_IDLE; // [RULE10] [RULE11]
          rsp_d.valid = 1'b1;
          eraseRun_d = 1'b0;
        end else if (tmo_q >= 40'(BUSY_LIMIT_CYC)) begin
          state_d = ST_IDLE; // [RULE17]
          rsp_d = '{valid: 1'b1, err: 1'b1, data: rsp_q.data};
          eraseRun_d = 1'b0;
        end
      end
      ST_RD: begin
        if (cnt_q == 9'd0 && dqS2_q == dqS3_q) begin
          rsp_d = '{valid: 1'b1, err: 1'b0, data: dqS3_q}; // [RULE19]
          state_d = ST_IDLE;
          pins_d.outEnN = 1'b1;
          pins_d.die0SelectN = 1'b1;
          pins_d.die1SelectN = 1'b1;
        end
      end
      ST_RST_LOW: begin
        if (cnt_q == 9'd0) begin
          pins_d.resetN = 1'b1;
          state_d = ST_RST_REC;
          cnt_d = 9'(fce_pkg::RH_CYC - 1);
        end
      end
      ST_RST_REC: begin
        bypass_d = 1'b0; // [RULE15]
        susp_d = 1'b0;
        eraseRun_d = 1'b0;
        if (cnt_q == 9'd0) begin
          state_d = ST_IDLE;
          rsp_d.valid = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end
  // sequencer registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      pins_q <= fce_pkg::PINS_RST;
      rsp_q <= '0;
      idx_q <= 3'd0;
      cnt_q <= 9'd0;
      tmo_q <= 40'd0;
      bypass_q <= 1'b0;
      susp_q <= 1'b0;
      eraseRun_q <= 1'b0;
      doneStable_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      pins_q <= pins_d;
      rsp_q <= rsp_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      bypass_q <= bypass_d;
      susp_q <= susp_d;
      eraseRun_q <= eraseRun_d;
      doneStable_q <= doneStable_d;
    end
  end
  // outputs
  assign pins = pins_q;
  assign rsp = rsp_q;
  assign bypassActive = bypassEff;
  assign eraseSuspended = susp_q;
endmodule

/* fce_flash_model.sv */
// behavioural dual-die flash answering the host pins
`timescale 1ns/1ns
module fce_flash_model #(
  parameter int PROG_CYC = 40,
  parameter int ERASE_CYC = 300,
  parameter int PROT_SEC = 5
) (
  // timer clock
  input wire logic ref_clk,
  // host pins and supply state
  input fce_pkg::fce_pins_t pins,
  input wire logic lowSupply,
  // outputs to the host
  output logic [7:0] dqIn,
  output logic opDonePin
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  logic [7:0] pd = 8'h00;
  int st [2] = '{0, 0};
  bit byp [2] = '{0, 0};
  int busy = 0;
  int hold = 0;
  int ers [$];
  int kill [$];
  bit sus = 0;
  bit tog = 0;
  // unwritten bytes read erased
  function automatic logic [7:0] rd(int k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction
  // decode each write of the selected die at the strobe rising edge
  always @(posedge pins.writeEnN) begin : dec
    int d, k;
    logic [7:0] v;
    d = pins.die0SelectN;
    k = {pins.die0SelectN, pins.addr};
    v = pins.dqOut;
    if (pins.resetN && !lowSupply && !(pins.die0SelectN && pins.die1SelectN)) begin
      if (st[d] == 8 && v != 8'h30) st[d] = 0;
      if (st[d] == 2 && v == 8'h20) byp[d] = 1'b1;
      if (st[d] == 7 && v == 8'h00) byp[d] = 1'b0;
      if (st[d] == 5 && (k >> 16) % 128 != PROT_SEC) mem[k] = rd(k) & v;
      if (st[d] == 5) pd = v;
      if (st[d] == 5) busy = PROG_CYC;
      if (st[d] == 6 && v == 8'h10) for (int s = 0; s < 128; s++) ers.push_back(d * 128 + s);
      if ((st[d] == 6 || st[d] == 8) && v == 8'h30) ers.push_back(k >> 16);
      if ((st[d] == 6 && v == 8'h10) || ((st[d] == 6 || st[d] == 8) && v == 8'h30)) busy = ERASE_CYC;
      if (st[d] == 0 && v == 8'h30 && sus) busy = hold;
      if (st[d] == 0 && v == 8'h30) sus = 1'b0;
      if (st[d] == 0 && v == 8'hb0 && ers.size() > 0 && !sus) hold = busy;
      if (st[d] == 0 && v == 8'hb0 && ers.size() > 0) sus = 1'b1;
      if (st[d] == 0 && v == 8'hb0) busy = 0;
      case (st[d])
        0: st[d] = v == 8'haa ? 1 : v == 8'ha0 && (byp[d] || pins.fastProgramEn) ? 5 :
          v == 8'h90 && byp[d] ? 7 : 0;
        1: st[d] = v == 8'h55 ? 2 : 0;
        2: st[d] = v == 8'ha0 ? 5 : v == 8'h80 ? 3 : 0;
        3: st[d] = v == 8'haa ? 4 : 0;
        4: st[d] = v == 8'h55 ? 6 : 0;
        6, 8: st[d] = v == 8'h30 ? 8 : 0;
        default: st[d] = 0;
      endcase
    end
  end
  // algorithm timer off the host's sampling edge; a finished erase clears its unprotected sectors
  always @(negedge ref_clk) begin
    if (busy == 1 && !sus && ers.size() > 0) begin
      foreach (mem[k]) if ((k >> 16) inside {ers} && (k >> 16) % 128 != PROT_SEC) kill.push_back(k);
      foreach (kill[i]) mem.delete(kill[i]);
      kill.delete();
      ers.delete();
    end
    if (busy > 0) busy = busy - 1;
    last <= dqIn;
  end
  // hardware reset aborts everything
  always @(negedge pins.resetN) begin
    st = '{0, 0};
    byp = '{0, 0};
    busy = 0;
    sus = 0;
    ers.delete();
  end
  // status while busy, array data when idle, inverse of last when released
  always @(negedge pins.outEnN) tog = ~tog;
  assign opDonePin = (busy == 0);
  always @* begin
    if (!pins.outEnN && !(pins.die0SelectN && pins.die1SelectN)) begin
      dqIn = (busy != 0) ? {~pd[7], tog, 6'h00} : rd({pins.die0SelectN, pins.addr});
    end else begin
      dqIn = ~last;
    end
  end
endmodule

/* fce_host_checker.sv */
// port assertions for the flash host controller
`timescale 1ns/1ns
module fce_host_checker #(
  parameter longint unsigned BUSY_LIMIT_CYC = 2000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // user side
  input wire logic cmdValid,
  input wire logic cmdReady,
  input fce_pkg::fce_cmd_t cmd,
  input wire logic fastMode,
  input fce_pkg::fce_rsp_t rsp,
  input wire logic bypassActive,
  input wire logic eraseSuspended,
  // flash side
  input fce_pkg::fce_pins_t pins,
  input wire logic [7:0] dqIn,
  input wire logic opDonePin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // write strobe low phase, then high phase
  sequence weLow_s;
    (!pins.writeEnN) [*8] ##1 !pins.writeEnN ##1 pins.writeEnN;
  endsequence
  sequence weHigh_s;
    pins.writeEnN [*8];
  endsequence
  one_select_a: assert property (pins.die0SelectN || pins.die1SelectN)
    else $error("both die selects low");
  we_select_a: assert property (!pins.writeEnN |->
    pins.outEnN && pins.dqOe && !(pins.die0SelectN && pins.die1SelectN))
    else $error("write strobe without select or data");
  we_low_a: assert property ($fell(pins.writeEnN) |-> weLow_s)
    else $error("write pulse length wrong");
  we_high_a: assert property ($rose(pins.writeEnN) |-> weHigh_s)
    else $error("write high time short");
  reset_len_a: assert property ($fell(pins.resetN) |-> ##124 !pins.resetN ##1 pins.resetN)
    else $error("reset pulse length wrong");
  busy_hold_a: assert property ((!opDonePin && !pins.dqOe) [*4] |-> !rsp.valid)
    else $error("response while flash busy");
  rsp_pulse_a: assert property (rsp.valid |=> !rsp.valid)
    else $error("response longer than one cycle");
  fast_pin_a: assert property ($rose(fastMode) |=> pins.fastProgramEn && bypassActive)
    else $error("fast program pin not raised");
endmodule
bind fce_host fce_host_checker #(.BUSY_LIMIT_CYC(BUSY_LIMIT_CYC)) i_fce_host_checker (.ref_clk, .arst_n, .cmdValid,
  .cmdReady, .cmd, .fastMode, .rsp, .bypassActive, .eraseSuspended, .pins, .dqIn, .opDonePin);

/* fce_host_tb.sv */
// self-checking bench: host controller against the flash model
`timescale 1ns/1ns
module fce_host_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic fastMode = 1'b0;
  logic lowSupply = 1'b0;
  logic cmdReady, bypassActive, eraseSuspended, opDonePin;
  logic [7:0] dqIn, v, w;
  logic [22:0] a;
  logic d;
  fce_pkg::fce_cmd_t cmd = '0;
  fce_pkg::fce_rsp_t rsp;
  fce_pkg::fce_pins_t pins;
  int error_cnt = 0;
  int total_checks = 0;
  // clock
  always #2 ref_clk = ~ref_clk;
  // design and flash model
  fce_host #(.BUSY_LIMIT_CYC(2000)) i_fce_host (.ref_clk, .arst_n, .cmdValid, .cmdReady, .cmd, .fastMode,
    .rsp, .bypassActive, .eraseSuspended, .pins, .dqIn, .opDonePin);
  fce_flash_model i_fce_flash_model (.ref_clk, .pins, .lowSupply, .dqIn, .opDonePin);
  // expected values
  function automatic logic [22:0] sa(int s, logic [15:0] o);
    return {s[6:0], o};
  endfunction
  function automatic logic [7:0] pgm(logic [7:0] o, logic [7:0] n);
    return o & n;
  endfunction
  // verdict
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // one command: held until taken, then optionally its response
  task automatic run(input fce_pkg::fce_op_t op, input logic die, input logic [22:0] ad,
      input logic [7:0] da = 8'h00, input logic more = 1'b0, input bit rspWait = 1'b1);
    int n;
    logic rdy;
    n = 0;
    cmd = '{op: op, die: die, addr: ad, data: da, more: more};
    cmdValid = 1'b1;
    do begin
      @(negedge ref_clk);
      rdy = cmdReady;
      @(posedge ref_clk);
      n++;
    end while (rdy !== 1'b1 && n < 9000);
    #1 cmdValid = 1'b0;
    while (rspWait && rsp.valid !== 1'b1 && n < 9000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (rspWait) check("response error", 8'h00, {7'h00, rsp.err});
    if (n >= 9000) check("handshake", 8'h01, 8'h00);
  endtask
  task automatic look(input logic die, input logic [22:0] ad, input logic [7:0] e);
    run(fce_pkg::OP_READ, die, ad);
    check("read data", e, rsp.data);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hb4045863));
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    // random programs on random dice
    for (int i = 0; i < 4; i++) begin
      d = 1'($urandom);
      a = sa(8 + i, 16'($urandom));
      v = 8'($urandom);
      w = 8'($urandom);
      look(d, a, 8'hff);
      run(fce_pkg::OP_PROGRAM, d, a, v);
      run(fce_pkg::OP_PROGRAM, d, a, w);
      look(d, a, pgm(v, w));
      look(!d, a, 8'hff);
    end
    // bypass by command, then by the fast program pin
    run(fce_pkg::OP_BYPASS_ENTER, 1'b0, '0);
    check("bypass flag", 8'h01, {7'h00, bypassActive});
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(32, 16'h0001), 8'h5a);
    look(1'b0, sa(32, 16'h0001), 8'h5a);
    run(fce_pkg::OP_BYPASS_EXIT, 1'b0, '0);
    check("bypass flag", 8'h00, {7'h00, bypassActive});
    fastMode = 1'b1;
    run(fce_pkg::OP_PROGRAM, 1'b1, sa(33, 16'hffff), 8'h3c);
    look(1'b1, sa(33, 16'hffff), 8'h3c);
    fastMode = 1'b0;
    // single, multi-sector and whole-die erase
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(3, 16'h0000), 8'h00);
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(4, 16'hffff), 8'h00);
    run(fce_pkg::OP_SECTOR_ERASE, 1'b0, sa(3, 16'h0000));
    look(1'b0, sa(3, 16'h0000), 8'hff);
    look(1'b0, sa(4, 16'hffff), 8'h00);
    run(fce_pkg::OP_SECTOR_ERASE, 1'b0, sa(4, 16'h0000), 8'h00, 1'b1);
    run(fce_pkg::OP_SECTOR_ADD, 1'b0, sa(32, 16'h0000));
    look(1'b0, sa(4, 16'hffff), 8'hff);
    look(1'b0, sa(32, 16'h0001), 8'hff);
    run(fce_pkg::OP_CHIP_ERASE, 1'b1, '0);
    look(1'b1, sa(33, 16'hffff), 8'hff);
    // protected sector and low supply drop the program
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(5, 16'h0010), 8'h00);
    look(1'b0, sa(5, 16'h0010), 8'hff);
    lowSupply = 1'b1;
    run(fce_pkg::OP_PROGRAM, 1'b1, sa(6, 16'h0010), 8'h00);
    lowSupply = 1'b0;
    look(1'b1, sa(6, 16'h0010), 8'hff);
    // erase suspended for a program elsewhere, then resumed
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(7, 16'h0000), 8'h00);
    run(fce_pkg::OP_SECTOR_ERASE, 1'b0, sa(7, 16'h0000), 8'h00, 1'b0, 1'b0);
    @(posedge ref_clk);
    #1 run(fce_pkg::OP_SUSPEND, 1'b0, '0);
    check("suspended", 8'h01, {7'h00, eraseSuspended});
    run(fce_pkg::OP_PROGRAM, 1'b0, sa(40, 16'h0002), 8'h0f);
    look(1'b0, sa(40, 16'h0002), 8'h0f);
    run(fce_pkg::OP_RESUME, 1'b0, '0);
    check("suspended", 8'h00, {7'h00, eraseSuspended});
    look(1'b0, sa(7, 16'h0000), 8'hff);
    // hardware reset clears bypass; soft reset leaves the device usable
    run(fce_pkg::OP_BYPASS_ENTER, 1'b1, '0);
    run(fce_pkg::OP_HW_RESET, 1'b1, '0);
    check("bypass flag", 8'h00, {7'h00, bypassActive});
    run(fce_pkg::OP_SOFT_RESET, 1'b1, '0);
    run(fce_pkg::OP_PROGRAM, 1'b1, sa(41, 16'h0003), 8'ha5);
    look(1'b1, sa(41, 16'h0003), 8'ha5);
    finish_test();
  end
  // hang guard
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
